// ==== include/fcs_pkg.sv ====
package fcs_pkg;

	// Register byte addresses
	localparam logic [15:0] FCS_LOOP_ENABLE_CTRL_OFS = 16'h1C00;
	localparam logic [15:0] FCS_LOCK_REF_RATIO_CTRL_OFS = 16'h1C04;
	localparam logic [15:0] FCS_FRACTION_CTRL_OFS = 16'h1C08;
	localparam logic [15:0] FCS_LOOP_GAIN_MODE_DIVIDER_CTRL_OFS = 16'h1C0C;
	localparam logic [15:0] FCS_SIGMA_DELTA_ORDER_CTRL_OFS = 16'h1C34;
	localparam logic [15:0] FCS_LOOP_STATUS_OFS = 16'h1C38;

	// Reset values and writable masks
	localparam logic [31:0] FCS_LOOP_ENABLE_RST = 32'h0000_0002;
	localparam logic [31:0] FCS_LOOP_ENABLE_MASK = 32'h0000_0003;
	localparam logic [31:0] FCS_LOCK_REF_RATIO_RST = 32'h8820_0004;
	localparam logic [31:0] FCS_LOCK_REF_RATIO_MASK = 32'hF863_F3FF;
	localparam logic [31:0] FCS_FRACTION_RST = 32'h0000_0000;
	localparam logic [31:0] FCS_GAIN_MODE_RST = 32'h21F0_5001;
	localparam logic [31:0] FCS_GAIN_MODE_MASK = 32'hFFFF_73FF;
	localparam logic [31:0] FCS_SD_ORDER_RST = 32'h0000_0000;
	localparam logic [31:0] FCS_SD_ORDER_MASK = 32'h0000_0400;

	// Loop enable register fields
	localparam int FCS_LOOP_EN_BIT = 0;
	localparam int FCS_HOLD_BIT = 1;
	localparam int FCS_CTRL_UPD_BIT = 2;

	// Lock, reference and ratio register fields
	localparam int FCS_LOCK_THR_LSB = 28;
	localparam int FCS_LOCKDET_EN_BIT = 27;
	localparam int FCS_PHASEDET_BIT = 22;
	localparam int FCS_REFDET_EN_BIT = 21;
	localparam int FCS_REF_DIV_LSB = 16;
	localparam int FCS_REF_SRC_LSB = 12;
	localparam int FCS_INT_MULT_LSB = 0;

	// Fraction register fields
	localparam int FCS_FRAC_DEN_LSB = 16;
	localparam int FCS_FRAC_NUM_LSB = 0;

	// Gain, mode and divider fields
	localparam int FCS_PD_FINE_LSB = 28;
	localparam int FCS_PD_COARSE_LSB = 24;
	localparam int FCS_FD_FINE_LSB = 20;
	localparam int FCS_FD_COARSE_LSB = 16;
	localparam int FCS_INTEG_DLY_BIT = 14;
	localparam int FCS_MODE_LSB = 12;
	localparam int FCS_FB_DIV_LSB = 0;

	localparam int FCS_SD_ORDER2_BIT = 10;

	// Status register fields
	localparam int FCS_STS_LOCK_BIT = 0;
	localparam int FCS_STS_REF_BIT = 1;

	// Gain field code meaning disabled
	localparam logic [3:0] FCS_FD_FINE_OFF = 4'hF;

	// Detector timing in core clock cycles
	localparam logic [7:0] FCS_REF_TIMEOUT_CYC = 8'h40;
	localparam logic [3:0] FCS_LOCK_QUAL_CYC = 4'hF;

	typedef enum logic [1:0]
	{
		FCS_MODE_RSVD0 = 2'b00,
		FCS_MODE_INTEGER = 2'b01,
		FCS_MODE_RSVD2 = 2'b10,
		FCS_MODE_FRACTIONAL = 2'b11
	} fcs_mode_t;

	typedef enum logic [0:0]
	{
		FCS_GPIO_LOCK = 1'b0,
		FCS_GPIO_CLOCK = 1'b1
	} fcs_gpio_sel_t;

	// Two's complement gain code to exponent X, gain is 2 to the minus X
	function automatic logic signed [4:0] fcs_gain_exp(input logic [3:0] code);
		fcs_gain_exp = {code[3], code};
	endfunction

endpackage

// ==== hw/fcs_ctrl.sv ====
// Summary of operation
// - Report reference-present and loop-locked status signals.
// - Lock status is only reported while lock-detect enable is set.
// - Lock judged against the 4-bit lock threshold field.
// - Lock threshold affects only lock status, never loop configuration.
// - Reference-present status only generated while reference-detect enable is set.
// - Both status signals go out to the interrupt controller.
// - Qualified lock status selectable onto the general-purpose pin.
// - Loop-derived clock selectable onto the general-purpose pin.
// - Control update written while enabled applies pending fields to loop.
module fcs_ctrl
	import fcs_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// Register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Loop observation
	input wire logic i_ref_clk,
	input wire logic [3:0] i_lock_error,
	input wire logic i_loop_clk_out,
	input wire fcs_pkg::fcs_gpio_sel_t i_gpio_sel,
	// Status to interrupt controller and pin
	output logic o_lock_status,
	output logic o_ref_present,
	output logic o_gpio_out,
	// Applied loop configuration
	output logic o_loop_enable,
	output logic o_hold,
	output logic o_phase_det,
	output logic signed [4:0] o_pd_fine_exp,
	output logic signed [4:0] o_pd_coarse_exp,
	output logic [3:0] o_fd_fine_exp,
	output logic o_fd_fine_disable,
	output logic signed [4:0] o_fd_coarse_exp,
	output logic o_integ_delay,
	output logic o_integer_mode,
	output logic o_fractional_mode,
	output logic o_mode_reserved,
	output logic [9:0] o_feedback_divide_ratio,
	output logic o_second_order_sigma_delta_enable,
	output logic [9:0] o_integer_multiplier,
	output logic [15:0] o_fraction_numerator,
	output logic [15:0] o_fraction_denominator,
	output logic [1:0] o_reference_divide_setting,
	output logic [3:0] o_ref_source
);

	logic [31:0] enable_q;
	logic [31:0] lock_ratio_q;
	logic [31:0] fraction_q;
	logic [31:0] gain_mode_q;
	logic [31:0] sd_order_q;
	logic [31:0] app_ratio_q;
	logic [31:0] app_fraction_q;
	logic [31:0] app_gain_q;
	logic [31:0] app_sd_q;
	logic upd_wr;
	logic lock_detect_enable;
	logic reference_detect_enable;
	logic [3:0] lock_threshold;
	logic ref_s1_q;
	logic ref_s2_q;
	logic ref_s3_q;
	logic [7:0] ref_cnt_q;
	logic ref_present_q;
	logic [3:0] lock_cnt_q;
	logic [3:0] lock_cnt_d;
	logic lock_q;
	fcs_mode_t mode;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	assign lock_detect_enable = lock_ratio_q[FCS_LOCKDET_EN_BIT];
	assign reference_detect_enable = lock_ratio_q[FCS_REFDET_EN_BIT];
	assign lock_threshold = lock_ratio_q[FCS_LOCK_THR_LSB +: 4];
	assign upd_wr = i_reg_wr && (i_reg_addr == FCS_LOOP_ENABLE_CTRL_OFS) && i_reg_wdata[FCS_CTRL_UPD_BIT]
		&& enable_q[FCS_LOOP_EN_BIT];

	// Pending register writes; update bit is a strobe and is not stored
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			enable_q <= FCS_LOOP_ENABLE_RST;
			lock_ratio_q <= FCS_LOCK_REF_RATIO_RST;
			fraction_q <= FCS_FRACTION_RST;
			gain_mode_q <= FCS_GAIN_MODE_RST;
			sd_order_q <= FCS_SD_ORDER_RST;
		end
		else if (i_clk_en && i_reg_wr)
		begin
			unique case (i_reg_addr)
				FCS_LOOP_ENABLE_CTRL_OFS: enable_q <= i_reg_wdata & FCS_LOOP_ENABLE_MASK;
				FCS_LOCK_REF_RATIO_CTRL_OFS: lock_ratio_q <= i_reg_wdata & FCS_LOCK_REF_RATIO_MASK;
				FCS_FRACTION_CTRL_OFS: fraction_q <= i_reg_wdata;
				FCS_LOOP_GAIN_MODE_DIVIDER_CTRL_OFS: gain_mode_q <= i_reg_wdata & FCS_GAIN_MODE_MASK;
				FCS_SIGMA_DELTA_ORDER_CTRL_OFS: sd_order_q <= i_reg_wdata & FCS_SD_ORDER_MASK;
				default: ;
			endcase
		end
	end

	// Applied copies change only on an update strobe, never on threshold writes
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			app_ratio_q <= FCS_LOCK_REF_RATIO_RST;
			app_fraction_q <= FCS_FRACTION_RST;
			app_gain_q <= FCS_GAIN_MODE_RST;
			app_sd_q <= FCS_SD_ORDER_RST;
		end
		else if (i_clk_en && upd_wr)
		begin
			app_ratio_q <= lock_ratio_q;
			app_fraction_q <= fraction_q;
			app_gain_q <= gain_mode_q;
			app_sd_q <= sd_order_q;
		end
	end

	// Register read
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_reg_rdata <= 32'h0000_0000;
			o_reg_rvalid <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
			begin
				unique case (i_reg_addr)
					FCS_LOOP_ENABLE_CTRL_OFS: o_reg_rdata <= enable_q;
					FCS_LOCK_REF_RATIO_CTRL_OFS: o_reg_rdata <= lock_ratio_q;
					FCS_FRACTION_CTRL_OFS: o_reg_rdata <= fraction_q;
					FCS_LOOP_GAIN_MODE_DIVIDER_CTRL_OFS: o_reg_rdata <= gain_mode_q;
					FCS_SIGMA_DELTA_ORDER_CTRL_OFS: o_reg_rdata <= sd_order_q;
					FCS_LOOP_STATUS_OFS: o_reg_rdata <= {30'h0000_0000, o_ref_present, o_lock_status};
					default: o_reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Reference clock synchroniser
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			ref_s1_q <= i_ref_clk;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
		end
	end

	// Reference present while edges keep arriving within the timeout
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ref_cnt_q <= FCS_REF_TIMEOUT_CYC;
			ref_present_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (ref_s2_q != ref_s3_q)
				ref_cnt_q <= 8'h00;
			else if (ref_cnt_q != FCS_REF_TIMEOUT_CYC)
				ref_cnt_q <= ref_cnt_q + 8'h01;
			ref_present_q <= reference_detect_enable && (ref_cnt_q != FCS_REF_TIMEOUT_CYC);
		end
	end

	// Lock qualifies after error stays within threshold for the qualifying time
	always_comb
	begin
		lock_cnt_d = 4'h0;
		if (lock_detect_enable && enable_q[FCS_LOOP_EN_BIT] && ref_present_q && (i_lock_error <= lock_threshold))
			lock_cnt_d = (lock_cnt_q == FCS_LOCK_QUAL_CYC) ? lock_cnt_q : lock_cnt_q + 4'h1;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lock_cnt_q <= 4'h0;
			lock_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			lock_cnt_q <= lock_cnt_d;
			lock_q <= lock_detect_enable && (lock_cnt_d == FCS_LOCK_QUAL_CYC);
		end
	end
	assign o_lock_status = lock_q;
	assign o_ref_present = ref_present_q;
	// Clock path must not be resampled, so the pin mux is combinational
	assign o_gpio_out = (i_gpio_sel == FCS_GPIO_CLOCK) ? i_loop_clk_out : lock_q;
	assign mode = fcs_mode_t'(app_gain_q[FCS_MODE_LSB +: 2]);
	assign o_integer_mode = (mode == FCS_MODE_INTEGER);
	assign o_fractional_mode = (mode == FCS_MODE_FRACTIONAL);
	assign o_mode_reserved = (mode == FCS_MODE_RSVD0) || (mode == FCS_MODE_RSVD2);
	assign o_pd_fine_exp = fcs_gain_exp(app_gain_q[FCS_PD_FINE_LSB +: 4]);
	assign o_pd_coarse_exp = fcs_gain_exp(app_gain_q[FCS_PD_COARSE_LSB +: 4]);
	assign o_fd_coarse_exp = fcs_gain_exp(app_gain_q[FCS_FD_COARSE_LSB +: 4]);
	assign o_fd_fine_exp = app_gain_q[FCS_FD_FINE_LSB +: 4];
	assign o_fd_fine_disable = (app_gain_q[FCS_FD_FINE_LSB +: 4] == FCS_FD_FINE_OFF);
	assign o_integ_delay = app_gain_q[FCS_INTEG_DLY_BIT];
	assign o_feedback_divide_ratio = app_gain_q[FCS_FB_DIV_LSB +: 10];
	assign o_second_order_sigma_delta_enable = app_sd_q[FCS_SD_ORDER2_BIT];
	assign o_integer_multiplier = app_ratio_q[FCS_INT_MULT_LSB +: 10];
	assign o_reference_divide_setting = app_ratio_q[FCS_REF_DIV_LSB +: 2];
	assign o_ref_source = app_ratio_q[FCS_REF_SRC_LSB +: 4];
	assign o_phase_det = app_ratio_q[FCS_PHASEDET_BIT];
	assign o_fraction_numerator = app_fraction_q[FCS_FRAC_NUM_LSB +: 16];
	assign o_fraction_denominator = app_fraction_q[FCS_FRAC_DEN_LSB +: 16];
	assign o_loop_enable = enable_q[FCS_LOOP_EN_BIT];
	assign o_hold = enable_q[FCS_HOLD_BIT];

	sequence s_upd_write;
		i_clk_en && upd_wr;
	endsequence
	sequence s_no_update;
		i_clk_en && !upd_wr;
	endsequence
	property p_lock_needs_enable;
		(i_clk_en && !lock_detect_enable) |=> !o_lock_status;
	endproperty
	a_lock_needs_enable: assert property (p_lock_needs_enable) else $error("lock reported with detect off");
	property p_ref_needs_enable;
		(i_clk_en && !reference_detect_enable) |=> !o_ref_present;
	endproperty
	a_ref_needs_enable: assert property (p_ref_needs_enable) else $error("reference reported with detect off");
	property p_lock_drops_on_error;
		(i_clk_en && (i_lock_error > lock_threshold)) |=> !o_lock_status;
	endproperty
	a_lock_drops_on_error: assert property (p_lock_drops_on_error) else $error("lock kept above threshold");
	property p_lock_rise_cause;
		$rose(o_lock_status) |-> $past(i_lock_error) <= $past(lock_threshold) && $past(ref_present_q);
	endproperty
	a_lock_rise_cause: assert property (p_lock_rise_cause) else $error("lock rose without cause");
	property p_ref_timeout;
		(i_clk_en && ref_cnt_q == FCS_REF_TIMEOUT_CYC) |=> !o_ref_present;
	endproperty
	a_ref_timeout: assert property (p_ref_timeout) else $error("reference kept after timeout");
	property p_cfg_stable;
		s_no_update |=> $stable(app_gain_q) && $stable(app_ratio_q) && $stable(app_fraction_q);
	endproperty
	a_cfg_stable: assert property (p_cfg_stable) else $error("applied config changed without update");
	property p_update_applies;
		s_upd_write |=> app_gain_q == $past(gain_mode_q) && app_sd_q == $past(sd_order_q);
	endproperty
	a_update_applies: assert property (p_update_applies) else $error("update did not apply fields");
	property p_gpio_lock;
		(i_gpio_sel == FCS_GPIO_LOCK) |-> o_gpio_out == o_lock_status;
	endproperty
	a_gpio_lock: assert property (p_gpio_lock) else $error("pin does not carry lock");
	property p_gpio_clock;
		(i_gpio_sel == FCS_GPIO_CLOCK) |-> o_gpio_out == i_loop_clk_out;
	endproperty
	a_gpio_clock: assert property (p_gpio_clock) else $error("pin does not carry loop clock");
	property p_mode_decode;
		o_fractional_mode |-> app_gain_q[FCS_MODE_LSB +: 2] == 2'b11 && !o_integer_mode && !o_mode_reserved;
	endproperty
	a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");
	property p_fd_fine_off;
		o_fd_fine_disable |-> o_fd_fine_exp == 4'hF && o_pd_fine_exp == {app_gain_q[31], app_gain_q[31:28]};
	endproperty
	a_fd_fine_off: assert property (p_fd_fine_off) else $error("gain decode wrong");

endmodule

// ==== verification/tb.sv ====
module tb
	import fcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_clk_en = 1'b1;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [15:0] i_reg_addr = 16'h0000;
	logic [31:0] i_reg_wdata = 32'h0000_0000;
	logic i_ref_clk = 1'b0;
	logic [3:0] i_lock_error = 4'h0;
	logic i_loop_clk_out = 1'b0;
	fcs_gpio_sel_t i_gpio_sel = FCS_GPIO_LOCK;
	logic [31:0] o_reg_rdata;
	logic o_reg_rvalid, o_lock_status, o_ref_present, o_gpio_out, o_loop_enable, o_hold, o_phase_det;
	logic signed [4:0] o_pd_fine_exp, o_pd_coarse_exp, o_fd_coarse_exp;
	logic [3:0] o_fd_fine_exp, o_ref_source;
	logic o_fd_fine_disable, o_integ_delay, o_integer_mode, o_fractional_mode, o_mode_reserved;
	logic [9:0] o_feedback_divide_ratio, o_integer_multiplier;
	logic o_second_order_sigma_delta_enable;
	logic [15:0] o_fraction_numerator, o_fraction_denominator;
	logic [1:0] o_reference_divide_setting;
	logic [33:0] cfg;
	logic [31:0] g, gp, f, rd_v, lr;
	logic ref_run = 1'b0;
	int errors = 0;
	int samples_checked = 0;

	fcs_ctrl u_fcs_ctrl (.i_core_clk, .i_resetn, .i_clk_en, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .o_reg_rvalid, .i_ref_clk, .i_lock_error, .i_loop_clk_out, .i_gpio_sel, .o_lock_status,
		.o_ref_present, .o_gpio_out, .o_loop_enable, .o_hold, .o_phase_det, .o_pd_fine_exp, .o_pd_coarse_exp,
		.o_fd_fine_exp, .o_fd_fine_disable, .o_fd_coarse_exp, .o_integ_delay, .o_integer_mode,
		.o_fractional_mode, .o_mode_reserved, .o_feedback_divide_ratio, .o_second_order_sigma_delta_enable,
		.o_integer_multiplier, .o_fraction_numerator, .o_fraction_denominator, .o_reference_divide_setting,
		.o_ref_source);

	assign cfg = {o_pd_fine_exp, o_pd_coarse_exp, o_fd_fine_exp, o_fd_fine_disable, o_fd_coarse_exp,
		o_integ_delay, o_integer_mode, o_fractional_mode, o_mode_reserved, o_feedback_divide_ratio};

	always #4 i_core_clk = ~i_core_clk;
	// Reference edges asynchronous to the core clock
	always #27 if (ref_run) i_ref_clk = ~i_ref_clk;

	function automatic logic [33:0] dec(input logic [31:0] v);
		dec = {v[31], v[31:28], v[27], v[27:24], v[23:20], v[23:20] == 4'hF, v[19], v[19:16], v[14],
			v[13:12] == 2'b01, v[13:12] == 2'b11, !v[12], v[9:0]};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_core_clk) #1;
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(posedge i_core_clk) #1;
		i_reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge i_core_clk) #1;
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		@(posedge i_core_clk) #1;
		i_reg_rd = 1'b0;
		chk(o_reg_rvalid, 1'b1);
		d = o_reg_rdata;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	// Bounded wait on lock (s=1) or reference (s=0)
	task automatic waitv(input bit s, input logic v, input int n);
		for (int i = 0; i < n && (s ? o_lock_status : o_ref_present) !== v; i++)
			cycles(1);
		chk(s ? o_lock_status : o_ref_present, v);
		if (errors != 0)
			summarize();
	endtask

	initial
	begin
		#500us;
		errors++;
		summarize();
	end

	initial
	begin
		void'($urandom(32'hB131));
		cycles(12);
		i_resetn = 1'b1;
		chk(cfg, dec(FCS_GAIN_MODE_RST));
		rd(FCS_LOOP_ENABLE_CTRL_OFS, rd_v);
		chk(rd_v, FCS_LOOP_ENABLE_RST);
		rd(FCS_LOCK_REF_RATIO_CTRL_OFS, rd_v);
		chk(rd_v, FCS_LOCK_REF_RATIO_RST);
		rd(FCS_LOOP_GAIN_MODE_DIVIDER_CTRL_OFS, rd_v);
		chk(rd_v, FCS_GAIN_MODE_RST);
		rd(FCS_SIGMA_DELTA_ORDER_CTRL_OFS, rd_v);
		chk(rd_v, FCS_SD_ORDER_RST);
		rd(16'h1C10, rd_v);
		chk(rd_v, 32'h0000_0000);
		// Each mode code, last one with the high-frequency fractional settings
		gp = FCS_GAIN_MODE_RST;
		for (int k = 0; k < 4; k++)
		begin
			g = $urandom();
			g[13:12] = k[1:0];
			lr = $urandom();
			f = $urandom();
			if (k == 3)
			begin
				g = 32'h21F0_7001;
				lr = FCS_LOCK_REF_RATIO_RST;
				f = 32'h007D_000C;
			end
			wr(FCS_LOOP_GAIN_MODE_DIVIDER_CTRL_OFS, g);
			wr(FCS_SIGMA_DELTA_ORDER_CTRL_OFS, 32'hFFFF_FFFF);
			wr(FCS_LOCK_REF_RATIO_CTRL_OFS, lr);
			wr(FCS_FRACTION_CTRL_OFS, f);
			rd(FCS_LOOP_GAIN_MODE_DIVIDER_CTRL_OFS, rd_v);
			chk(rd_v, g & FCS_GAIN_MODE_MASK);
			if (k == 0)
			begin
				wr(FCS_LOOP_ENABLE_CTRL_OFS, 32'h0000_0004);
				chk(cfg, dec(FCS_GAIN_MODE_RST));
				chk(o_second_order_sigma_delta_enable, 1'b0);
			end
			wr(FCS_LOOP_ENABLE_CTRL_OFS, 32'h0000_0001);
			chk(cfg, dec(gp));
			wr(FCS_LOOP_ENABLE_CTRL_OFS, 32'h0000_0005);
			chk(cfg, dec(g));
			chk({o_integer_multiplier, o_reference_divide_setting, o_ref_source, o_phase_det}, {lr[9:0], lr[17:16], lr[15:12], lr[22]});
			chk({o_fraction_denominator, o_fraction_numerator}, f);
			chk({o_integer_mode, o_fractional_mode, o_mode_reserved}, {k == 1, k == 3, k == 0 || k == 2});
			chk(o_second_order_sigma_delta_enable, 1'b1);
			gp = g;
		end
		rd(FCS_SIGMA_DELTA_ORDER_CTRL_OFS, rd_v);
		chk(rd_v, FCS_SD_ORDER_MASK);
		i_clk_en = 1'b0;
		wr(FCS_LOOP_ENABLE_CTRL_OFS, 32'h0000_0000);
		i_clk_en = 1'b1;
		chk({o_loop_enable, o_hold}, 2'b10);
		// Reference detect and lock qualification
		i_lock_error = 4'($urandom_range(8));
		ref_run = 1'b1;
		waitv(0, 1'b1, 30);
		cycles(8);
		chk(o_lock_status, 1'b0);
		waitv(1, 1'b1, 20);
		i_gpio_sel = FCS_GPIO_LOCK;
		#1;
		chk(o_gpio_out, 1'b1);
		i_gpio_sel = FCS_GPIO_CLOCK;
		for (int b = 0; b < 2; b++)
		begin
			i_loop_clk_out = b[0];
			#1;
			chk(o_gpio_out, b[0]);
		end
		rd(FCS_LOOP_STATUS_OFS, rd_v);
		chk(rd_v[1:0], 2'b11);
		lr = {4'h3, FCS_LOCK_REF_RATIO_RST[27:0]};
		wr(FCS_LOCK_REF_RATIO_CTRL_OFS, lr);
		chk(cfg, dec(g));
		i_lock_error = 4'h4;
		waitv(1, 1'b0, 3);
		i_lock_error = 4'h3;
		waitv(1, 1'b1, 20);
		lr[FCS_LOCKDET_EN_BIT] = 1'b0;
		wr(FCS_LOCK_REF_RATIO_CTRL_OFS, lr);
		waitv(1, 1'b0, 3);
		cycles(20);
		chk(o_lock_status, 1'b0);
		ref_run = 1'b0;
		cycles(40);
		chk(o_ref_present, 1'b1);
		waitv(0, 1'b0, 40);
		lr[FCS_REFDET_EN_BIT] = 1'b0;
		wr(FCS_LOCK_REF_RATIO_CTRL_OFS, lr);
		ref_run = 1'b1;
		cycles(30);
		chk(o_ref_present, 1'b0);
		ref_run = 1'b0;
		summarize();
	end
endmodule
